// *** src/cau_top.sv ***
// Memory-mapped CRC accumulator with result, spare and control registers.
`timescale 1ns/1ps
`include "cau_defines.svh"

module cau_top
    import cau_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire cau_bus_req_t bus_req_in,
    output logic [31:0] bus_rdata_out,
    output logic calc_busy_out
);

    logic [31:0] result_ff;
    logic [31:0] nxt_result;
    logic [`CAU_SPARE_W-1:0] spare_ff;
    logic pend_ff;
    logic [31:0] pend_word_ff;
    logic nxt_pend;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    logic eng_busy;
    logic eng_last;
    logic [31:0] eng_crc_next;

    // Address decode; the low two bits must be zero since only aligned
    // word transfers are expected from the host.
    wire aligned_w = (bus_req_in.addr[1:0] == 2'h0);
    wire sel_result_w = aligned_w && (bus_req_in.addr == `CAU_OFS_RESULT);
    wire sel_spare_w = aligned_w && (bus_req_in.addr == `CAU_OFS_SPARE);
    wire sel_ctl_w = aligned_w && (bus_req_in.addr == `CAU_OFS_CTL);

    wire word_wr_w = bus_req_in.wr && sel_result_w;
    wire spare_wr_w = bus_req_in.wr && sel_spare_w;
    wire reinit_w = bus_req_in.wr && sel_ctl_w
        && bus_req_in.wdata[`CAU_CTL_REINIT_BIT];

    // The engine can take a word when idle or in its final step.
    wire free_w = !eng_busy || eng_last;
    wire pend_take_w = pend_ff && free_w;
    wire direct_w = word_wr_w && !pend_ff && free_w;
    wire wr_buf_w = word_wr_w && (pend_ff || !free_w);
    wire start_w = !reinit_w && (pend_take_w || direct_w);
    wire [31:0] start_word_w = pend_ff ? pend_word_ff : bus_req_in.wdata;
    // A word started in the final step chains onto the value finishing now.
    wire [31:0] seed_w = eng_last ? eng_crc_next : result_ff;

    cau_engine u_engine (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .start_in(start_w),
        .abort_in(reinit_w),
        .word_in(start_word_w),
        .seed_in(seed_w),
        .busy_out(eng_busy),
        .last_out(eng_last),
        .crc_next_out(eng_crc_next)
    );

    // A word that arrives while one is queued and the engine is not in its final step replaces it; the host
    // must pace writes to one per calculation period to keep every word.
    assign nxt_pend = reinit_w ? 1'b0 :
                      wr_buf_w ? 1'b1 :
                      pend_take_w ? 1'b0 : pend_ff;

    assign nxt_result = reinit_w ? `CAU_RESULT_RST :
                        eng_last ? eng_crc_next : result_ff;

    // Reads return the stored result, never the last written word. The
    // control bit clears in the write cycle itself, so it always reads zero.
    assign nxt_rdata = !bus_req_in.rd ? rdata_ff :
                       sel_result_w ? result_ff :
                       sel_spare_w ? {24'h000000, spare_ff} :
                       32'h00000000;

    assign calc_busy_out = eng_busy || pend_ff;
    assign bus_rdata_out = rdata_ff;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            result_ff <= `CAU_RESULT_RST;
        end else begin
            result_ff <= nxt_result;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            spare_ff <= `CAU_SPARE_RST;
        end else if (spare_wr_w) begin
            spare_ff <= bus_req_in.wdata[`CAU_SPARE_W-1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pend_ff <= 1'b0;
            pend_word_ff <= 32'h00000000;
            rdata_ff <= 32'h00000000;
        end else begin
            pend_ff <= nxt_pend;
            rdata_ff <= nxt_rdata;
            if (wr_buf_w) begin
                pend_word_ff <= bus_req_in.wdata;
            end
        end
    end

    // Checks on the register behaviour.
    default clocking cau_cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // Expected fold of the word that starts now, for the latency check.
    wire [31:0] exp_w = cau_crc_word(seed_w, start_word_w);

    sequence start_s;
        start_w;
    endsequence

    // Calm cycles after a start, so no reinitialisation cuts the word short.
    sequence quiet4_s;
        (!reinit_w)[*4];
    endsequence

    sequence guard3_s;
        (!reinit_w)[*3];
    endsequence

    ctl_reads_zero_a: assert property (
        bus_req_in.rd && sel_ctl_w |=> bus_rdata_out == 32'h00000000)
        else $error("control register did not read as zero");

    reset_seed_a: assert property (
        $fell(sys_rst_in) |-> result_ff == 32'hffffffff)
        else $error("result not all ones after reset");

    read_result_a: assert property (
        bus_req_in.rd && sel_result_w |=> bus_rdata_out == $past(result_ff))
        else $error("result read did not return stored result");

    spare_store_a: assert property (
        spare_wr_w ##1 (!spare_wr_w)[*2] |->
            spare_ff == $past(bus_req_in.wdata[7:0], 2))
        else $error("spare byte lost its written value");

    spare_upper_a: assert property (
        bus_req_in.rd && sel_spare_w |=> bus_rdata_out[31:8] == 24'h000000)
        else $error("spare upper bits not zero");

    spare_reinit_a: assert property (
        reinit_w |=> $stable(spare_ff))
        else $error("reinitialisation changed spare byte");

    reinit_seed_a: assert property (
        reinit_w |=> result_ff == 32'hffffffff && !eng_busy && !pend_ff)
        else $error("reinitialisation did not reload seed");

    calc_latency_a: assert property (
        start_s ##1 quiet4_s |=> result_ff == $past(exp_w, 5))
        else $error("result wrong or late four clocks after start");

    hold_result_a: assert property (
        !reinit_w && !eng_last |=> $stable(result_ff))
        else $error("result changed without completed calculation");

    no_stall_a: assert property (
        word_wr_w && eng_busy && !eng_last && !reinit_w |=>
            pend_ff && pend_word_ff == $past(bus_req_in.wdata))
        else $error("word written during calculation was not buffered");

    // The bench cannot see the engine's steps, so they are checked here.
    rst_outputs_a: assert property (
        $fell(sys_rst_in) |-> !calc_busy_out && bus_rdata_out == 32'h00000000)
        else $error("outputs not idle after reset");

    unmapped_zero_a: assert property (
        bus_req_in.rd && !sel_result_w && !sel_spare_w |=>
            bus_rdata_out == 32'h00000000)
        else $error("unmapped or control read did not return zero");

    rdata_hold_a: assert property (
        !bus_req_in.rd |=> $stable(bus_rdata_out))
        else $error("read data changed without a read");

    spare_write_a: assert property (
        spare_wr_w |=> spare_ff == $past(bus_req_in.wdata[7:0]))
        else $error("spare byte write did not land");

    mid_busy_a: assert property (
        start_s ##1 guard3_s |-> eng_busy && !eng_last)
        else $error("engine not busy in the middle of a calculation");

    last_step_a: assert property (
        start_s ##1 guard3_s |=> eng_last)
        else $error("engine final step not in fourth cycle");

    buffer_drain_a: assert property (
        pend_ff && free_w && !reinit_w && !word_wr_w |=>
            !pend_ff && eng_busy)
        else $error("buffered word did not start when engine freed");

    pend_wait_a: assert property (
        pend_ff |-> eng_busy)
        else $error("buffered word waiting on an idle engine");

    busy_word_a: assert property (
        word_wr_w |=> calc_busy_out)
        else $error("busy not raised after a data word write");

endmodule

// *** src/cau_defines.svh ***
// Register offsets, reset values and timing counts of the CRC accumulator.
`ifndef CAU_DEFINES_SVH
`define CAU_DEFINES_SVH

`define CAU_ADDR_W 8
`define CAU_OFS_RESULT 8'h00
`define CAU_OFS_SPARE 8'h04
`define CAU_OFS_CTL 8'h08
`define CAU_RESULT_RST 32'hffffffff
`define CAU_SPARE_RST 8'h00
`define CAU_SPARE_W 8
`define CAU_CTL_REINIT_BIT 0
`define CAU_POLY 32'h04c11db7
`define CAU_CALC_CYCLES 3'h4
`define CAU_CNT_W 3

`endif

// *** src/cau_pkg.sv ***
// Types and the shared byte-step CRC function of the CRC accumulator.
`include "cau_defines.svh"

package cau_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [`CAU_ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } cau_bus_req_t;

    // Folds one byte into the running value, most significant bit first.
    function automatic logic [31:0] cau_crc_byte(input logic [31:0] acc,
                                                 input logic [7:0] din);
        logic [31:0] c;
        logic fb;
        c = acc;
        fb = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            fb = c[31] ^ din[i];
            c = {c[30:0], 1'b0} ^ (fb ? `CAU_POLY : 32'h00000000);
        end
        return c;
    endfunction

    function automatic logic [31:0] cau_crc_word(input logic [31:0] acc,
                                                 input logic [31:0] din);
        logic [31:0] c;
        c = cau_crc_byte(acc, din[31:24]);
        c = cau_crc_byte(c, din[23:16]);
        c = cau_crc_byte(c, din[15:8]);
        c = cau_crc_byte(c, din[7:0]);
        return c;
    endfunction

endpackage

// *** src/cau_engine.sv ***
// Sequential CRC engine that folds one byte per clock into a seed.
`timescale 1ns/1ps
`include "cau_defines.svh"

module cau_engine
    import cau_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic start_in,
    input wire logic abort_in,
    input wire logic [31:0] word_in,
    input wire logic [31:0] seed_in,
    output logic busy_out,
    output logic last_out,
    output logic [31:0] crc_next_out
);

    logic [31:0] acc_ff;
    logic [31:0] data_ff;
    logic [`CAU_CNT_W-1:0] cnt_ff;

    // One byte per edge spreads the work over four edges and keeps the
    // combinational depth to eight feedback stages.
    assign crc_next_out = cau_crc_byte(acc_ff, data_ff[31:24]);
    assign busy_out = (cnt_ff != '0);
    assign last_out = (cnt_ff == `CAU_CNT_W'(1));

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || abort_in) begin
            cnt_ff <= '0;
        end else if (start_in) begin
            cnt_ff <= `CAU_CALC_CYCLES;
        end else if (busy_out) begin
            cnt_ff <= cnt_ff - `CAU_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            acc_ff <= `CAU_RESULT_RST;
            data_ff <= 32'h00000000;
        end else if (start_in) begin
            acc_ff <= seed_in;
            data_ff <= word_in;
        end else if (busy_out) begin
            acc_ff <= crc_next_out;
            data_ff <= {data_ff[23:0], 8'h00};
        end
    end

endmodule

// *** test/cau_top_tb_top.sv ***
// Self-checking testbench of the CRC accumulator register interface.
`timescale 1ns/1ps
`include "cau_defines.svh"

module cau_top_tb_top
    import cau_pkg::*;
;
    logic clk_in;
    logic sys_rst_in;
    cau_bus_req_t bus_req;
    logic [31:0] rdata;
    logic busy;
    logic [31:0] exp_crc;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;

    cau_top i_dut (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .bus_req_in(bus_req),
        .bus_rdata_out(rdata),
        .calc_busy_out(busy)
    );

    // The reference works bit by bit so that it shares no code with the design.
    function automatic logic [31:0] ref_crc(input logic [31:0] a,
                                            input logic [31:0] d);
        for (int i = 31; i >= 0; i--) begin
            a = {a[30:0], 1'b0} ^ ((a[31] ^ d[i]) ? `CAU_POLY : 32'h00000000);
        end
        return a;
    endfunction

    task automatic close_out();
        if (bad_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask

    // Each access task is entered at a falling edge and uses one cycle.
    task automatic idle();
        bus_req = '0;
        @(negedge clk_in);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_in);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input string name);
        bus_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h00000000};
        @(negedge clk_in);
        chk(name, exp, rdata);
    endtask

    // Bounded wait, so a stuck busy flag shows up as a mismatch.
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 20) begin
            idle();
            n++;
        end
        chk("busy cleared", 32'h00000000, {31'h00000000, busy});
    endtask

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        sys_rst_in = 1'b1;
        bus_req = '0;
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        sys_rst_in = 1'b0;
        idle();
        rd(`CAU_OFS_RESULT, `CAU_RESULT_RST, "result reset");
        rd(`CAU_OFS_SPARE, 32'h00000000, "spare reset");
        rd(`CAU_OFS_CTL, 32'h00000000, "control reset");
        rd(8'h0c, 32'h00000000, "unmapped read");
        exp_crc = ref_crc(`CAU_RESULT_RST, 32'h12345678);
        wr(`CAU_OFS_RESULT, 32'h12345678);
        idle();
        idle();
        idle();
        chk("busy cycle four", 32'h00000001, {31'h00000000, busy});
        rd(`CAU_OFS_RESULT, `CAU_RESULT_RST, "result during calc");
        chk("busy cycle five", 32'h00000000, {31'h00000000, busy});
        rd(`CAU_OFS_RESULT, exp_crc, "result four later");
        // Back-to-back words exercise the one-word input buffer.
        wr(`CAU_OFS_RESULT, 32'hdeadbeef);
        wr(`CAU_OFS_RESULT, 32'h00000001);
        wait_idle();
        exp_crc = ref_crc(ref_crc(exp_crc, 32'hdeadbeef), 32'h00000001);
        rd(`CAU_OFS_RESULT, exp_crc, "chained result");
        wr(`CAU_OFS_SPARE, 32'h12345aa5);
        rd(`CAU_OFS_SPARE, 32'h000000a5, "spare byte");
        rd(`CAU_OFS_RESULT, exp_crc, "result after spare");
        wr(`CAU_OFS_CTL, 32'h00000001);
        rd(`CAU_OFS_RESULT, `CAU_RESULT_RST, "result reinit");
        rd(`CAU_OFS_CTL, 32'h00000000, "control cleared");
        rd(`CAU_OFS_SPARE, 32'h000000a5, "spare kept");
        wr(`CAU_OFS_RESULT, 32'h80000000);
        wait_idle();
        exp_crc = ref_crc(`CAU_RESULT_RST, 32'h80000000);
        rd(`CAU_OFS_RESULT, exp_crc, "result from seed");
        wr(`CAU_OFS_CTL, 32'h00000000);
        rd(`CAU_OFS_RESULT, exp_crc, "result after zero control");
        wr(`CAU_OFS_RESULT, 32'h0badf00d);
        wr(`CAU_OFS_RESULT, 32'h00c0ffee);
        wr(`CAU_OFS_CTL, 32'h00000001);
        wait_idle();
        rd(`CAU_OFS_RESULT, `CAU_RESULT_RST, "reinit mid calc");
        wr(`CAU_OFS_RESULT, 32'h00c0ffee);
        wait_idle();
        exp_crc = ref_crc(`CAU_RESULT_RST, 32'h00c0ffee);
        rd(`CAU_OFS_RESULT, exp_crc, "result after cancel");
        idle();
        close_out();
    end
endmodule
